// ### rtl/fmt_pkg.sv
// Constants shared by the sync and serial output formatter.
package fmt_pkg;
  // Lane modes.
  localparam logic [1:0] LANE_TWO     = 2'h0;
  localparam logic [1:0] LANE_ONE     = 2'h1;
  localparam logic [1:0] LANE_HALF    = 2'h2;
  // Resolution select codes.
  localparam logic [1:0] RES_14       = 2'h0;
  localparam logic [1:0] RES_16       = 2'h1;
  localparam logic [1:0] RES_18       = 2'h2;
  localparam logic [1:0] RES_20       = 2'h3;
  // Widths and positions.
  localparam int         ADC_W        = 14;
  localparam int         FILT_W       = 16;
  localparam int         WORD_W       = 40;
  localparam int         MSB_POS      = 39;
  localparam int         CNT_W        = 7;
  localparam int         DIV_W        = 5;
  // Resync grid of the divider, in sampling-clock cycles.
  localparam int         RESYNC_GRID  = 64;
  // Reset values.
  localparam logic [1:0] LANE_RST     = LANE_ONE;
  localparam logic [1:0] RES_RST      = RES_14;
  localparam logic [WORD_W-1:0] WORD_RST = 40'h00_0000_0000;
  // Decoded resolution in bits.
  function automatic logic [5:0] res_bits(input logic [1:0] sel);
    case (sel)
      RES_16:  res_bits = 6'h10;
      RES_18:  res_bits = 6'h12;
      RES_20:  res_bits = 6'h14;
      default: res_bits = 6'h0E;
    endcase
  endfunction : res_bits
endpackage : fmt_pkg

// ### rtl/decim_sync_serial_output_formatter.sv
// Divider alignment on sync and serial lane formatter for two channels.
// How it works
// - With sync enabled, the shared pin is a sync input latched per sample.
// - Sync comes from the register pulse or the pin.
// - Sync resets the decimation divider and the two-sample word pairing.
// - Sync also restarts the oscillator, exactly like the mixer restart bit.
// - Complex decimation: one frame per output sample, lane bits 2R/L.
// - Real decimation: two-lane frames hold two samples, others one.
// - Lane modes are two lanes, one lane, or two channels sharing one lane.
// - Samples are presented at 14, 16, 18 or 20 bits, default 14.
// - Without decimation at 16 bits or more the two LSBs are zero.
// - Bits per lane per frame follow resolution and lane mode.
// - Bit clock runs at half lane rate, so one bit per clock edge.
// - The bit formatting is used both in bypass and with decimation.
// - Lane mode, resolution and options are configuration inputs.
`timescale 1ns/100ps
`default_nettype none
module decim_sync_serial_output_formatter
  import fmt_pkg::*;
(
  // Clock and reset.
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Configuration.
  input  wire logic [1:0]        lane_mode,
  input  wire logic [1:0]        resolution_sel,
  input  wire logic              decim_enable,
  input  wire logic              decim_complex,
  input  wire logic [2:0]        decim_log2,
  input  wire logic              sync_enable,
  input  wire logic              sync_reg_pulse,
  input  wire logic              mixer_restart,
  // Sync pin and sampling clock strobe.
  input  wire logic              powerdown_or_align_pin,
  input  wire logic              sample_strobe,
  // Converter samples.
  input  wire logic [ADC_W-1:0]  adc_a,
  input  wire logic [ADC_W-1:0]  adc_b,
  // Filter outputs, valid on decim_tick.
  input  wire logic [FILT_W-1:0] filt_a_i,
  input  wire logic [FILT_W-1:0] filt_a_q,
  input  wire logic [FILT_W-1:0] filt_b_i,
  input  wire logic [FILT_W-1:0] filt_b_q,
  // Serial bit clock from the receiver.
  input  wire logic              serial_bit_clock_in,
  // Status and control toward the datapath.
  output logic                   powerdown,
  output logic                   decim_tick,
  output logic                   divider_reset,
  output logic                   nco_restart,
  // Serial link.
  output logic                   serial_bit_clock_out,
  output logic                   frame_clock_out,
  output logic [3:0]             channel_data_lanes
);

  logic              pin_latched;
  logic              pin_prev;
  logic              restart_prev;
  logic              sync_event;
  logic [DIV_W-1:0]  div_cnt;
  logic [DIV_W-1:0]  div_mask;
  logic              word_sel;
  logic [WORD_W-1:0] hold_a;
  logic [WORD_W-1:0] hold_b;
  logic [WORD_W-1:0] sh_a;
  logic [WORD_W-1:0] sh_b;
  logic              bclk_prev;
  logic              bit_edge;
  logic [CNT_W-1:0]  bit_cnt;
  logic [CNT_W-1:0]  frame_bits;
  logic [5:0]        res;
  logic              two_words;
  logic              sample_ev;
  logic [19:0]       word_a;
  logic [19:0]       word_b;
  logic [19:0]       pend_a;
  logic [19:0]       pend_b;
  logic              on_b;

  // Keep the top R bits of a sample at the chosen resolution, right-justified in a 20-bit slot.
  function automatic logic [19:0] fmt_word(input logic [FILT_W-1:0] v, input logic [5:0] r, input logic dec);
    logic [19:0] w;
    w = {v, 4'h0};
    if (!dec) begin
      w[5:4] = 2'h0;
    end
    fmt_word = w >> (6'h14 - r);
  endfunction : fmt_word

  // Place two R-bit words MSB-first into a 40-bit channel word.
  function automatic logic [WORD_W-1:0] pack2(input logic [19:0] w0, input logic [19:0] w1, input logic [5:0] r);
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] b;
    a = {20'h00000, w0} << (7'h28 - {1'b0, r});
    b = {20'h00000, w1} << (7'h28 - {r, 1'b0});
    pack2 = a | b;
  endfunction : pack2

  assign res       = res_bits(resolution_sel);
  assign two_words = (lane_mode == LANE_TWO) || (decim_enable && decim_complex);
  assign div_mask  = DIV_W'((6'h01 << decim_log2) - 6'h01);
  assign sample_ev = decim_enable ? decim_tick : sample_strobe;
  assign word_a    = decim_enable ? fmt_word(filt_a_i, res, 1'b1) : fmt_word({adc_a, 2'h0}, res, 1'b0);
  assign word_b    = decim_enable ? fmt_word(filt_b_i, res, 1'b1) : fmt_word({adc_b, 2'h0}, res, 1'b0);
  // In half-lane mode channel B follows channel A on the one lane.
  assign on_b      = (lane_mode == LANE_HALF) && (bit_cnt >= (frame_bits >> 1));

  // Lane bits per frame.
  always_comb begin
    case (lane_mode)
      LANE_TWO:  frame_bits = {1'b0, res};
      LANE_HALF: frame_bits = (decim_enable && decim_complex) ? CNT_W'({res, 2'h0}) : CNT_W'({res, 1'b0});
      default:   frame_bits = (decim_enable && decim_complex) ? CNT_W'({res, 1'b0}) : {1'b0, res};
    endcase
  end

  assign powerdown = !sync_enable && pin_latched;

  // Pin is latched only on sampling clock edges.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pin_latched <= 1'b0;
      pin_prev    <= 1'b0;
    end else if (sample_strobe) begin
      pin_latched <= powerdown_or_align_pin;
      pin_prev    <= pin_latched;
    end
  end

  // Rising pin level or register pulse forms the sync event.
  assign sync_event = sync_reg_pulse || (sync_enable && sample_strobe && pin_latched && !pin_prev);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      restart_prev  <= 1'b0;
      nco_restart   <= 1'b0;
      divider_reset <= 1'b0;
    end else begin
      restart_prev  <= mixer_restart;
      nco_restart   <= sync_event || (mixer_restart && !restart_prev);
      divider_reset <= sync_event;
    end
  end

  // Decimation divider; the caller keeps resyncs on the 64-cycle grid.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      div_cnt    <= '0;
      decim_tick <= 1'b0;
    end else if (sync_event) begin
      div_cnt    <= '0;
      decim_tick <= 1'b0;
    end else begin
      decim_tick <= 1'b0;
      if (sample_strobe) begin
        div_cnt    <= (div_cnt + 5'h01) & div_mask;
        decim_tick <= decim_enable && ((div_cnt & div_mask) == div_mask);
      end
    end
  end

  // Assemble the channel words that the next frame will carry.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hold_a   <= WORD_RST;
      hold_b   <= WORD_RST;
      pend_a   <= '0;
      pend_b   <= '0;
      word_sel <= 1'b0;
    end else if (sync_event) begin
      word_sel <= 1'b0;
    end else if (sample_ev) begin
      if (decim_enable && decim_complex) begin
        hold_a <= pack2(fmt_word(filt_a_i, res, 1'b1), fmt_word(filt_a_q, res, 1'b1), res);
        hold_b <= pack2(fmt_word(filt_b_i, res, 1'b1), fmt_word(filt_b_q, res, 1'b1), res);
      end else if (!two_words) begin
        hold_a <= pack2(word_a, 20'h00000, res);
        hold_b <= pack2(word_b, 20'h00000, res);
      end else if (!word_sel) begin
        // The first word waits here so that a frame never carries half a pair.
        pend_a <= word_a;
        pend_b <= word_b;
      end else begin
        hold_a <= pack2(pend_a, word_a, res);
        hold_b <= pack2(pend_b, word_b, res);
      end
      word_sel <= !(decim_enable && decim_complex) && two_words && !word_sel;
    end
  end

  // Each edge of the receiver's bit clock moves one bit per lane.
  assign bit_edge = serial_bit_clock_in ^ bclk_prev;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bclk_prev            <= 1'b0;
      serial_bit_clock_out <= 1'b0;
    end else begin
      bclk_prev            <= serial_bit_clock_in;
      serial_bit_clock_out <= bclk_prev;
    end
  end

  // Shift out the frame; reload at the frame's last bit.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sh_a               <= WORD_RST;
      sh_b               <= WORD_RST;
      bit_cnt            <= '0;
      frame_clock_out    <= 1'b0;
      channel_data_lanes <= 4'h0;
    end else if (bit_edge) begin
      frame_clock_out <= (bit_cnt < (frame_bits >> 1));
      case (lane_mode)
        LANE_TWO: begin
          channel_data_lanes <= {sh_b[MSB_POS], sh_b[MSB_POS - res], sh_a[MSB_POS], sh_a[MSB_POS - res]};
        end
        LANE_HALF: begin
          channel_data_lanes <= {3'h0, on_b ? sh_b[MSB_POS] : sh_a[MSB_POS]};
        end
        default: begin
          channel_data_lanes <= {1'b0, sh_b[MSB_POS], 1'b0, sh_a[MSB_POS]};
        end
      endcase
      if (bit_cnt >= frame_bits - 7'h01) begin
        bit_cnt <= '0;
        sh_a    <= hold_a;
        sh_b    <= hold_b;
      end else begin
        bit_cnt <= bit_cnt + 7'h01;
        if (lane_mode != LANE_HALF || !on_b) begin
          sh_a <= {sh_a[MSB_POS-1:0], 1'b0};
        end
        if (lane_mode != LANE_HALF || on_b) begin
          sh_b <= {sh_b[MSB_POS-1:0], 1'b0};
        end
      end
    end
  end

endmodule : decim_sync_serial_output_formatter
`default_nettype wire

// ### test/fmt_monitor.sv
// Checker for the sync and serial output formatter.
`timescale 1ns/100ps
`default_nettype none
module fmt_monitor (
  // Clock, reset and controls.
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       sync_enable,
  input wire logic       sync_reg_pulse,
  input wire logic       mixer_restart,
  input wire logic       powerdown_or_align_pin,
  input wire logic       sample_strobe,
  input wire logic       serial_bit_clock_in,
  // Outputs.
  input wire logic       powerdown,
  input wire logic       decim_tick,
  input wire logic       divider_reset,
  input wire logic       nco_restart,
  input wire logic       serial_bit_clock_out,
  input wire logic       frame_clock_out,
  input wire logic [3:0] channel_data_lanes
);
  logic pin_hit;
  assign pin_hit = sync_enable & sample_strobe & powerdown_or_align_pin;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_SYNC_DIV: assert property (sync_reg_pulse |=> divider_reset) else $error("divider reset missing");
  AST_SYNC_NCO: assert property (sync_reg_pulse |=> nco_restart) else $error("restart missing");
  AST_MIX_NCO: assert property ($rose(mixer_restart) |=> nco_restart) else $error("mixer restart lost");
  AST_DIV_CAUSE: assert property (divider_reset |-> $past(sync_reg_pulse) || $past(pin_hit))
    else $error("divider reset without sync");
  AST_NCO_CAUSE: assert property (nco_restart |-> divider_reset || $past(mixer_restart))
    else $error("restart without cause");
  AST_PD_OFF: assert property (sync_enable |-> !powerdown) else $error("powerdown while sync");
  AST_TICK: assert property (decim_tick |-> $past(sample_strobe)) else $error("tick off strobe");
  AST_ECHO: assert property ($past(nrst) && $past(nrst, 2) |-> serial_bit_clock_out == $past(serial_bit_clock_in, 2))
    else $error("bit clock echo wrong");
  AST_FRAME_EDGE: assert property ($past(nrst) && ($changed(frame_clock_out) || $changed(channel_data_lanes))
    |=> $changed(serial_bit_clock_out)) else $error("lane change off bit edge");
  cover property (divider_reset);
  cover property (nco_restart && !divider_reset);
  cover property ($rose(frame_clock_out));
endmodule : fmt_monitor
bind decim_sync_serial_output_formatter fmt_monitor fmt_monitor_i (.core_clk(core_clk), .nrst(nrst),
  .sync_enable(sync_enable), .sync_reg_pulse(sync_reg_pulse), .mixer_restart(mixer_restart),
  .powerdown_or_align_pin(powerdown_or_align_pin), .sample_strobe(sample_strobe),
  .serial_bit_clock_in(serial_bit_clock_in), .powerdown(powerdown), .decim_tick(decim_tick),
  .divider_reset(divider_reset), .nco_restart(nco_restart), .serial_bit_clock_out(serial_bit_clock_out),
  .frame_clock_out(frame_clock_out), .channel_data_lanes(channel_data_lanes));
`default_nettype wire

// ### test/rx_model.sv
// Receiver model: supplies the bit clock and deserializes one lane.
`timescale 1ns/100ps
`default_nettype none
module rx_model #(parameter int HALF = 3) (
  input  wire logic   core_clk,
  input  wire logic   bit_clk_back,
  input  wire logic   frame_clk,
  input  wire logic   lane,
  output logic        bit_clk_out = 1'b0,
  output logic [63:0] rx_word = 64'h0,
  output logic [6:0]  rx_len = 7'h00,
  output logic [15:0] rx_frames = 16'h0000
);
  logic [63:0] sh = 64'h0;
  logic [6:0]  cnt = 7'h00;
  logic [6:0]  tcnt = 7'h00;
  logic        prev_clk = 1'b0;
  logic        prev_frame = 1'b0;
  // Free-running bit clock locked to the core clock, slow enough for any lane rate.
  always_ff @(posedge core_clk) begin
    tcnt <= (tcnt == 7'(HALF - 1)) ? 7'h00 : tcnt + 7'h01;
    if (tcnt == 7'(HALF - 1)) bit_clk_out <= !bit_clk_out;
  end
  // Each change of the returned clock carries one bit; a frame clock rise starts a word.
  always_ff @(posedge core_clk) begin
    prev_clk <= bit_clk_back;
    if (bit_clk_back != prev_clk) begin
      prev_frame <= frame_clk;
      if (frame_clk && !prev_frame) begin
        rx_word <= sh;
        rx_len <= cnt;
        rx_frames <= rx_frames + 16'h0001;
        sh <= {63'h0, lane};
        cnt <= 7'h01;
      end else begin
        sh <= {sh[62:0], lane};
        cnt <= cnt + 7'h01;
      end
    end
  end
endmodule : rx_model
`default_nettype wire

// ### test/tb.sv
// Testbench for the sync and serial output formatter.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import fmt_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, decim_enable = 1'b0, decim_complex = 1'b0, sync_enable = 1'b0;
  logic sync_reg_pulse = 1'b0, mixer_restart = 1'b0, powerdown_or_align_pin = 1'b0, sample_strobe = 1'b0;
  logic [1:0] lane_mode = LANE_ONE, resolution_sel = RES_14, scnt = 2'h0;
  logic [2:0] decim_log2 = 3'h1;
  logic [ADC_W-1:0] adc_a = 14'h2A5C, adc_b = 14'h1C93;
  logic [FILT_W-1:0] filt_a_i = 16'hB3E1, filt_a_q = 16'h4C7A, filt_b_i = 16'h5A5A, filt_b_q = 16'hA5A5;
  logic powerdown, decim_tick, divider_reset, nco_restart, serial_bit_clock_in, serial_bit_clock_out;
  logic frame_clock_out;
  logic [3:0] channel_data_lanes;
  logic [63:0] rx_word;
  logic [6:0] rx_len;
  logic [15:0] rx_frames;
  int err_count = 0, checks_done = 0, cycles = 0, sync_at = 0;
  decim_sync_serial_output_formatter decim_sync_serial_output_formatter_i (.core_clk(core_clk), .nrst(nrst),
    .lane_mode(lane_mode), .resolution_sel(resolution_sel), .decim_enable(decim_enable),
    .decim_complex(decim_complex), .decim_log2(decim_log2), .sync_enable(sync_enable),
    .sync_reg_pulse(sync_reg_pulse), .mixer_restart(mixer_restart), .sample_strobe(sample_strobe),
    .powerdown_or_align_pin(powerdown_or_align_pin), .adc_a(adc_a), .adc_b(adc_b), .filt_a_i(filt_a_i),
    .filt_a_q(filt_a_q), .filt_b_i(filt_b_i), .filt_b_q(filt_b_q), .serial_bit_clock_in(serial_bit_clock_in),
    .powerdown(powerdown), .decim_tick(decim_tick), .divider_reset(divider_reset), .nco_restart(nco_restart),
    .serial_bit_clock_out(serial_bit_clock_out), .frame_clock_out(frame_clock_out),
    .channel_data_lanes(channel_data_lanes));
  rx_model rx_model_i (.core_clk(core_clk), .bit_clk_back(serial_bit_clock_out), .frame_clk(frame_clock_out),
    .lane(channel_data_lanes[0]), .bit_clk_out(serial_bit_clock_in), .rx_word(rx_word), .rx_len(rx_len),
    .rx_frames(rx_frames));
  initial forever #12.5 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    scnt <= scnt + 2'h1;
    sample_strobe <= (scnt == 2'h3);
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic fmt_case(input logic [1:0] lm, rs, input logic de, input logic [6:0] len, input logic [63:0] w);
    logic [15:0] f;
    @(negedge core_clk);
    lane_mode = lm;
    resolution_sel = rs;
    decim_enable = de;
    decim_complex = de;
    f = rx_frames + 16'h0003;
    for (int i = 0; i < 3000 && rx_frames < f; i++) @(negedge core_clk);
    if (rx_frames < f) err_count++;
    chk({57'h0, rx_len}, {57'h0, len});
    chk(rx_word, w);
  endtask : fmt_case
  task automatic t_sync;
    int seen;
    @(negedge core_clk);
    sync_reg_pulse = 1'b1;
    sync_at = cycles;
    @(negedge core_clk);
    sync_reg_pulse = 1'b0;
    chk({62'h0, divider_reset, nco_restart}, 64'h3);
    @(negedge core_clk);
    chk({62'h0, divider_reset, nco_restart}, 64'h0);
    mixer_restart = 1'b1;
    @(negedge core_clk);
    chk({62'h0, divider_reset, nco_restart}, 64'h1);
    mixer_restart = 1'b0;
    sync_enable = 1'b1;
    powerdown_or_align_pin = 1'b1;
    seen = 0;
    repeat (8) begin
      @(negedge core_clk);
      if (divider_reset === 1'b1) seen++;
    end
    chk(64'(seen), 64'h1);
    chk({63'h0, powerdown}, 64'h0);
    sync_enable = 1'b0;
    repeat (8) @(negedge core_clk);
    chk({63'h0, powerdown}, 64'h1);
    powerdown_or_align_pin = 1'b0;
  endtask : t_sync
  task automatic t_decim;
    int ticks;
    decim_enable = 1'b1;
    for (int l = 1; l < 4; l++) begin
      decim_log2 = 3'(l);
      ticks = 0;
      repeat (40) @(negedge core_clk);
      repeat (64) begin
        @(negedge core_clk);
        if (decim_tick === 1'b1) ticks++;
      end
      chk(64'(ticks), 64'(16 >> l));
    end
    decim_log2 = 3'h1;
    fmt_case(LANE_ONE, RES_16, 1'b1, 7'h20, {32'h0, filt_a_i, filt_a_q});
  endtask : t_decim
  task automatic t_resync;
    int n;
    decim_log2 = 3'h2;
    repeat (2) @(negedge core_clk);
    // Resync only on the 64-sample grid of the first sync; a sample lasts four core cycles here.
    while ((cycles - sync_at) % (RESYNC_GRID * 4) != 0) @(negedge core_clk);
    sync_reg_pulse = 1'b1;
    @(negedge core_clk);
    sync_reg_pulse = 1'b0;
    n = 0;
    while (decim_tick !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk(64'(n), 64'h0F);
  endtask : t_resync
  task automatic t_bypass;
    for (int r = 0; r < 4; r++) fmt_case(LANE_ONE, 2'(r), 1'b0, 7'(14 + 2 * r), {50'h0, adc_a} << (2 * r));
    fmt_case(LANE_HALF, RES_14, 1'b0, 7'h1C, {36'h0, adc_a, adc_b});
    fmt_case(LANE_TWO, RES_16, 1'b0, 7'h10, {48'h0, adc_a, 2'h0});
    fmt_case(2'h3, RES_14, 1'b0, 7'h0E, {50'h0, adc_a});
  endtask : t_bypass
  initial begin
    repeat (20) @(negedge core_clk);
    chk({57'h0, powerdown, decim_tick, divider_reset, nco_restart, frame_clock_out, channel_data_lanes}, 64'h0);
    nrst = 1'b1;
    t_sync();
    t_decim();
    t_resync();
    t_bypass();
    complete_run();
  end
endmodule : tb
`default_nettype wire
